//--- core/rfd_divider_timeout.sv
// RF feedback divider configuration and acquisition-boost timeout counter.
// Assumes pfd_event is a one-cycle pulse on clk from the phase detector.
//
// What this block does
// - Low-band variants: 15-bit binary count in word bits 21..7, range 3..32767.
// - High-band variant: 14-bit binary count in word bits 21..8, range 3..16383.
// - Low-band variants: prescaler select 0 gives 8/9, 1 gives 16/17.
// - High-band variant: prescaler select 0 gives 16/17, 1 gives 32/33.
// - Powerdown bit 23 clear keeps the loop active, set powers it down.
// - Pump high-impedance bit decides synchronous or asynchronous powerdown.
// - Timeout value is 12 bits in word bits 14..3; bits 23..15 are zero.
// - Timeout 0: boost pin high impedance, pump gain from gain select.
// - Timeout 1: pin driven low, pump forced to high gain indefinitely.
// - Timeout 2: pin driven low, pump gain from gain select.
// - Timeout 3: pin driven high, pump gain from gain select.
// - Timeout 4..4095: low with high gain for that many events, then release.
// - New timeout value takes effect only at the next phase-detector event.
// - Gain select 0 means low gain, 1 means high gain.
module rfd_divider_timeout #(
  parameter bit HIGH_BAND_VARIANT = 1'b0
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      ser_clk,
  input  wire logic                      ser_data,
  input  wire logic                      ser_latch,
  input  wire logic                      pfd_event,
  output logic [rfd_pkg::B_W-1:0]        rf_binary_divide_count,
  output logic                           rf_prescaler_modulus_select,
  output logic [5:0]                     rf_prescaler_lower_modulus,
  output logic                           rf_divide_illegal,
  output logic                           rf_loop_powerdown,
  output logic                           rf_pump_high_impedance,
  output logic                           rf_pump_high_gain,
  output logic                           rf_boost_output_pin_o,
  output logic                           rf_boost_output_pin_oe
);
  logic [rfd_pkg::WORD_W-1:0]  word;
  logic                        word_valid;
  logic [1:0]                  pump_q;
  logic [rfd_pkg::WORD_W-1:0]  div_q;
  logic [rfd_pkg::TOC_W-1:0]   toc_pend_q;
  logic                        toc_new_q;
  logic [rfd_pkg::TOC_W-1:0]   toc_act_q;
  logic [rfd_pkg::TOC_W-1:0]   boost_cnt_q;
  logic                        pin_o_d;
  logic                        pin_oe_d;
  logic                        gain_d;

  // Reset leaves the smallest legal count so the divider never starts from zero
  typedef logic [rfd_pkg::WORD_W-1:0] rfd_word_t;
  localparam rfd_word_t DIV_RESET = HIGH_BAND_VARIANT
                                    ? rfd_word_t'(rfd_pkg::B_MIN) << rfd_pkg::B_LSB_HIGH
                                    : rfd_word_t'(rfd_pkg::B_MIN) << rfd_pkg::B_LSB_LOW;

  function automatic logic [rfd_pkg::B_W-1:0] b_field(input logic [rfd_pkg::WORD_W-1:0] w);
    if (HIGH_BAND_VARIANT) begin
      b_field = {1'b0, w[rfd_pkg::B_MSB:rfd_pkg::B_LSB_HIGH]};
    end else begin
      b_field = w[rfd_pkg::B_MSB:rfd_pkg::B_LSB_LOW];
    end
  endfunction

  function automatic logic [5:0] lower_modulus(input logic sel);
    if (HIGH_BAND_VARIANT) begin
      lower_modulus = sel ? rfd_pkg::MOD_32 : rfd_pkg::MOD_16;
    end else begin
      lower_modulus = sel ? rfd_pkg::MOD_16 : rfd_pkg::MOD_8;
    end
  endfunction

  rfd_serial_rx u_rx (
    .clk          (clk),
    .reset        (reset),
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .ser_latch    (ser_latch),
    .word_q       (word),
    .word_valid_q (word_valid)
  );

  // Register decode by the address field of each latched word
  always_ff @(posedge clk) begin
    if (reset) begin
      pump_q <= rfd_pkg::PUMP_RESET;
      div_q  <= DIV_RESET;
    end else if (word_valid) begin
      if (word[rfd_pkg::ADDR_MSB:0] == rfd_pkg::ADDR_PUMP_CTRL) begin
        pump_q <= {word[rfd_pkg::PUMP_HIGHZ_BIT], word[rfd_pkg::PUMP_GAIN_BIT]};
      end
      if (word[rfd_pkg::ADDR_MSB:0] == rfd_pkg::ADDR_FB_DIV) begin
        div_q <= word;
      end
    end
  end

  // Upper bits of the timeout word are ignored by design
  always_ff @(posedge clk) begin
    if (reset) begin
      toc_pend_q <= rfd_pkg::TOC_TRISTATE;
    end else if (word_valid && word[rfd_pkg::ADDR_MSB:0] == rfd_pkg::ADDR_TIMEOUT) begin
      toc_pend_q <= word[rfd_pkg::TOC_MSB:rfd_pkg::TOC_LSB];
    end
  end

  // A write landing on the event cycle is kept for the following event
  always_ff @(posedge clk) begin
    if (reset) begin
      toc_new_q <= 1'b0;
    end else if (word_valid && word[rfd_pkg::ADDR_MSB:0] == rfd_pkg::ADDR_TIMEOUT) begin
      toc_new_q <= 1'b1;
    end else if (pfd_event) begin
      toc_new_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      toc_act_q   <= rfd_pkg::TOC_TRISTATE;
      boost_cnt_q <= rfd_pkg::TOC_TRISTATE;
    end else if (pfd_event && toc_new_q) begin
      toc_act_q   <= toc_pend_q;
      boost_cnt_q <= (toc_pend_q >= rfd_pkg::TOC_TIMED_MIN) ? toc_pend_q
                                                             : rfd_pkg::TOC_TRISTATE;
    end else if (pfd_event && boost_cnt_q != rfd_pkg::TOC_TRISTATE) begin
      boost_cnt_q <= boost_cnt_q - 12'h001;
    end
  end

  always_comb begin
    pin_o_d  = 1'b0;
    pin_oe_d = 1'b0;
    gain_d   = pump_q[0];
    case (toc_act_q)
      rfd_pkg::TOC_TRISTATE: begin
        pin_oe_d = 1'b0;
      end
      rfd_pkg::TOC_MANUAL: begin
        pin_oe_d = 1'b1;
        gain_d   = 1'b1;
      end
      rfd_pkg::TOC_GP_LOW: begin
        pin_oe_d = 1'b1;
      end
      rfd_pkg::TOC_GP_HIGH: begin
        pin_oe_d = 1'b1;
        pin_o_d  = 1'b1;
      end
      default: begin
        pin_oe_d = (boost_cnt_q != rfd_pkg::TOC_TRISTATE);
        gain_d   = (boost_cnt_q != rfd_pkg::TOC_TRISTATE);
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rf_boost_output_pin_o  <= 1'b0;
      rf_boost_output_pin_oe <= 1'b0;
      rf_pump_high_gain      <= 1'b0;
    end else begin
      rf_boost_output_pin_o  <= pin_o_d;
      rf_boost_output_pin_oe <= pin_oe_d;
      rf_pump_high_gain      <= gain_d;
    end
  end

  // Powering up is immediate; powering down waits for an event unless the pump is parked
  always_ff @(posedge clk) begin
    if (reset) begin
      rf_loop_powerdown <= 1'b0;
    end else if (!div_q[rfd_pkg::PD_BIT]) begin
      rf_loop_powerdown <= 1'b0;
    end else if (pump_q[1] || pfd_event) begin
      rf_loop_powerdown <= 1'b1;
    end
  end

  // Modulus is exported so the divider computes modulus * count + swallow
  always_ff @(posedge clk) begin
    if (reset) begin
      rf_binary_divide_count      <= rfd_pkg::B_MIN;
      rf_prescaler_modulus_select <= 1'b0;
      rf_prescaler_lower_modulus  <= lower_modulus(1'b0);
      rf_divide_illegal           <= 1'b0;
      rf_pump_high_impedance      <= 1'b0;
    end else begin
      rf_binary_divide_count      <= b_field(div_q);
      rf_prescaler_modulus_select <= div_q[rfd_pkg::PSEL_BIT];
      rf_prescaler_lower_modulus  <= lower_modulus(div_q[rfd_pkg::PSEL_BIT]);
      rf_divide_illegal           <= b_field(div_q) < rfd_pkg::B_MIN;
      rf_pump_high_impedance      <= pump_q[1];
    end
  end

  manual_boost_a: assert property (@(posedge clk) disable iff (reset)
    toc_act_q == rfd_pkg::TOC_MANUAL |=> rf_boost_output_pin_oe && !rf_boost_output_pin_o
                                        && rf_pump_high_gain)
    else $error("manual boost not driving low with high gain");

  idle_tristate_a: assert property (@(posedge clk) disable iff (reset)
    toc_act_q == rfd_pkg::TOC_TRISTATE |=> !rf_boost_output_pin_oe
                                          && rf_pump_high_gain == $past(pump_q[0]))
    else $error("timeout zero not tri-stated with selected gain");

  gp_low_a: assert property (@(posedge clk) disable iff (reset)
    toc_act_q == rfd_pkg::TOC_GP_LOW |=> rf_boost_output_pin_oe && !rf_boost_output_pin_o
                                        && rf_pump_high_gain == $past(pump_q[0]))
    else $error("general purpose low mode wrong");

  gp_high_a: assert property (@(posedge clk) disable iff (reset)
    toc_act_q == rfd_pkg::TOC_GP_HIGH |=> rf_boost_output_pin_oe && rf_boost_output_pin_o
                                         && rf_pump_high_gain == $past(pump_q[0]))
    else $error("general purpose high mode wrong");

  timed_release_a: assert property (@(posedge clk) disable iff (reset)
    toc_act_q >= rfd_pkg::TOC_TIMED_MIN && boost_cnt_q == rfd_pkg::TOC_TRISTATE
    |=> !rf_boost_output_pin_oe && !rf_pump_high_gain)
    else $error("boost not released after timeout");

  timed_load_a: assert property (@(posedge clk) disable iff (reset)
    pfd_event && toc_new_q && toc_pend_q >= rfd_pkg::TOC_TIMED_MIN
    |=> boost_cnt_q == $past(toc_pend_q) ##1 rf_boost_output_pin_oe && rf_pump_high_gain)
    else $error("timed boost not loaded and active");

  event_latch_a: assert property (@(posedge clk) disable iff (reset)
    !pfd_event |=> $stable(toc_act_q))
    else $error("timeout mode changed without an event");

  async_pd_a: assert property (@(posedge clk) disable iff (reset)
    div_q[rfd_pkg::PD_BIT] && pump_q[1] |=> rf_loop_powerdown)
    else $error("asynchronous powerdown did not act at once");

  sync_pd_a: assert property (@(posedge clk) disable iff (reset)
    !rf_loop_powerdown && !pump_q[1] && !pfd_event |=> !rf_loop_powerdown)
    else $error("synchronous powerdown acted without an event");

  prescaler_map_a: assert property (@(posedge clk) disable iff (reset)
    ##1 rf_prescaler_lower_modulus == (HIGH_BAND_VARIANT
      ? ($past(div_q[rfd_pkg::PSEL_BIT]) ? rfd_pkg::MOD_32 : rfd_pkg::MOD_16)
      : ($past(div_q[rfd_pkg::PSEL_BIT]) ? rfd_pkg::MOD_16 : rfd_pkg::MOD_8)))
    else $error("prescaler modulus mismatch");
endmodule // rfd_divider_timeout

//--- core/rfd_pkg.sv
// Constants for the RF feedback divider and acquisition-boost timeout block.
// Assumes 24-bit serial configuration words whose low three bits select the register.
package rfd_pkg;
  localparam int WORD_W   = 24;
  localparam int ADDR_MSB = 2;
  localparam int ADDR_W   = 3;

  localparam logic [ADDR_W-1:0] ADDR_PUMP_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_FB_DIV    = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_TIMEOUT   = 3'h2;

  // Charge-pump control word fields
  localparam int PUMP_GAIN_BIT  = 19;
  localparam int PUMP_HIGHZ_BIT = 20;

  // Feedback divider word fields
  localparam int PD_BIT      = 23;
  localparam int PSEL_BIT    = 22;
  localparam int B_MSB       = 21;
  localparam int B_LSB_LOW   = 7;
  localparam int B_LSB_HIGH  = 8;
  localparam int B_W         = 15;
  localparam logic [B_W-1:0] B_MIN = 15'h0003;

  localparam logic [5:0] MOD_8  = 6'h08;
  localparam logic [5:0] MOD_16 = 6'h10;
  localparam logic [5:0] MOD_32 = 6'h20;

  // Timeout word fields and modes
  localparam int TOC_MSB = 14;
  localparam int TOC_LSB = 3;
  localparam int TOC_W   = 12;
  localparam logic [TOC_W-1:0] TOC_TRISTATE  = 12'h000;
  localparam logic [TOC_W-1:0] TOC_MANUAL    = 12'h001;
  localparam logic [TOC_W-1:0] TOC_GP_LOW    = 12'h002;
  localparam logic [TOC_W-1:0] TOC_GP_HIGH   = 12'h003;
  localparam logic [TOC_W-1:0] TOC_TIMED_MIN = 12'h004;

  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
  localparam logic [1:0]        PUMP_RESET = 2'h0;
endpackage

//--- core/rfd_serial_rx.sv
// Three-wire serial word receiver: clock, data and latch pins.
// Assumes pins are asynchronous to clk and much slower than it.
module rfd_serial_rx (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       ser_clk,
  input  wire logic                       ser_data,
  input  wire logic                       ser_latch,
  output logic [rfd_pkg::WORD_W-1:0]      word_q,
  output logic                            word_valid_q
);
  logic [2:0]                  s1_q;
  logic [2:0]                  s2_q;
  logic [2:0]                  s3_q;
  logic [2:0]                  filt_q;
  logic [2:0]                  prev_q;
  logic [rfd_pkg::WORD_W-1:0]  shift_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {ser_latch, ser_data, ser_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A level change is believed only once two stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      filt_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
      prev_q <= filt_q;
    end
  end

  // Most significant bit first
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_q <= rfd_pkg::WORD_RESET;
    end else if (filt_q[0] && !prev_q[0]) begin
      shift_q <= {shift_q[rfd_pkg::WORD_W-2:0], filt_q[1]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      word_q       <= rfd_pkg::WORD_RESET;
      word_valid_q <= 1'b0;
    end else begin
      word_valid_q <= filt_q[2] && !prev_q[2];
      if (filt_q[2] && !prev_q[2]) begin
        word_q <= shift_q;
      end
    end
  end
endmodule // rfd_serial_rx

//--- test/rfd_divider_timeout_tb_top.sv
// Self-checking bench for the feedback divider and boost timeout block.
// Assumes the host model as the only writer of the serial port.
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module rfd_divider_timeout_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [23:0] w;
    logic        pfd;
    logic [14:0] c;
    logic        p;
    logic [5:0]  m;
    logic [4:0]  f;
    logic [14:0] hc;
    logic [5:0]  hm;
  } rfd_row_s;

  logic        clk;
  logic        reset;
  logic        pfd_event;
  logic        ser_clk;
  logic        ser_data;
  logic        ser_latch;
  logic [14:0] cnt;
  logic [14:0] hcnt;
  logic        psel;
  logic [5:0]  lmod;
  logic [5:0]  hlmod;
  logic        ill;
  logic        pd;
  logic        hz;
  logic        gain;
  logic        bo;
  logic        boe;
  logic [27:0] lo;
  int          errors;
  int          samples_checked;

  assign lo = {cnt, psel, lmod, ill, pd, hz, gain, bo, boe};

  // Field f is {powerdown, pump high-Z, high gain, pin value, pin enable}
  // Every count written is at least 3 for both variants
  rfd_row_s rows[15] = '{
    '{24'h000000, 1'h0, 15'h0003, 1'h0, 6'h08, 5'h00, 15'h0003, 6'h10},
    '{24'h7fff81, 1'h0, 15'h7fff, 1'h1, 6'h10, 5'h00, 15'h3fff, 6'h20},
    '{24'h000379, 1'h0, 15'h0006, 1'h0, 6'h08, 5'h00, 15'h0003, 6'h10},
    '{24'h00000a, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h05, 15'h0003, 6'h10},
    '{24'h000012, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h01, 15'h0003, 6'h10},
    '{24'h00001a, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h03, 15'h0003, 6'h10},
    '{24'h080000, 1'h0, 15'h0006, 1'h0, 6'h08, 5'h07, 15'h0003, 6'h10},
    '{24'hff8012, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h05, 15'h0003, 6'h10},
    '{24'hfffffd, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h05, 15'h0003, 6'h10},
    '{24'h000002, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h04, 15'h0003, 6'h10},
    '{24'h800379, 1'h0, 15'h0006, 1'h0, 6'h08, 5'h04, 15'h0003, 6'h10},
    '{24'h800379, 1'h1, 15'h0006, 1'h0, 6'h08, 5'h14, 15'h0003, 6'h10},
    '{24'h100000, 1'h0, 15'h0006, 1'h0, 6'h08, 5'h18, 15'h0003, 6'h10},
    '{24'h000379, 1'h0, 15'h0006, 1'h0, 6'h08, 5'h08, 15'h0003, 6'h10},
    '{24'h800379, 1'h0, 15'h0006, 1'h0, 6'h08, 5'h18, 15'h0003, 6'h10}
  };

  rfd_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

  rfd_divider_timeout #(.HIGH_BAND_VARIANT(1'b0)) uut (
    .clk(clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .pfd_event(pfd_event), .rf_binary_divide_count(cnt),
    .rf_prescaler_modulus_select(psel), .rf_prescaler_lower_modulus(lmod),
    .rf_divide_illegal(ill), .rf_loop_powerdown(pd), .rf_pump_high_impedance(hz),
    .rf_pump_high_gain(gain), .rf_boost_output_pin_o(bo), .rf_boost_output_pin_oe(boe)
  );

  rfd_divider_timeout #(.HIGH_BAND_VARIANT(1'b1)) uut_hb (
    .clk(clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .pfd_event(pfd_event), .rf_binary_divide_count(hcnt),
    .rf_prescaler_modulus_select(), .rf_prescaler_lower_modulus(hlmod),
    .rf_divide_illegal(), .rf_loop_powerdown(), .rf_pump_high_impedance(),
    .rf_pump_high_gain(), .rf_boost_output_pin_o(), .rf_boost_output_pin_oe()
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic pulse(input int k);
    repeat (k) begin
      pfd_event = 1'b1;
      @(negedge clk);
    end
    pfd_event = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic hold_reset();
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    `CHK(lo, {15'h0003, 1'b0, 6'h08, 1'b0, 5'h00})
  endtask

  // Timed boost: nothing before the latching event, then boost for it and n-1 further events, off at the next
  task automatic boost(input logic [11:0] n);
    host.send({9'h000, n, 3'h2});
    repeat (12) @(negedge clk);
    `CHK({bo, boe, gain}, 3'h0)
    pulse(1);
    `CHK({bo, boe, gain}, 3'h3)
    pulse(int'(n) - 1);
    `CHK({bo, boe, gain}, 3'h3)
    pulse(1);
    `CHK({bo, boe, gain}, 3'h0)
  endtask

  task automatic print_verdict();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    pfd_event = 1'b0;
    errors = 0;
    samples_checked = 0;
    hold_reset();
    foreach (rows[i]) begin
      host.send(rows[i].w);
      repeat (12) @(negedge clk);
      if (rows[i].pfd)
        pulse(1);
      `CHK(lo[27:6], {rows[i].c, rows[i].p, rows[i].m})
      `CHK(lo[5:4], {rows[i].c < 15'h0003, rows[i].f[4]})
      `CHK(lo[3:0], rows[i].f[3:0])
      `CHK({hcnt, hlmod}, {rows[i].hc, rows[i].hm})
    end
    // Reset in mid-run must return every low-band output to its idle value
    hold_reset();
    boost(12'h004);
    boost(12'hfff);
    print_verdict();
  end
endmodule // rfd_divider_timeout_tb_top

//--- test/rfd_host_model.sv
// Host model that writes 24-bit configuration words over the three-wire port.
// Assumes the block samples these pins with its own much faster clock.
module rfd_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_latch = 1'b0;
  end

  // Link clock runs only inside a frame, 64 ns period, most significant bit first.
  // Data is inverted after the last bit so a stale level is never read as a held one.
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #32 ser_clk = 1'b1;
      #32 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
    #32 ser_latch = 1'b1;
    #32 ser_latch = 1'b0;
    #32;
  endtask
endmodule // rfd_host_model
